// >>> verilog/sil1_ctrl.sv
// Layer 1 control: command/indication, D access, alignment, multiframe
// How it works
// - Code 0000 deactivates and stops clocks
// - Code 0001 resets, reports code 0001
// - 1000 activates; 1111 acknowledges final deactivation
// - 0011 continuous pulses, 0010 isolated pulses
// - Report resync, wake and synchronous codes
// - Report 1111 on timer or idle
// - Echo mismatch stops D, then monitor
// - Two classes: levels 8/9 and 10/11
// - 1000 sets priority 8, 1001 sets 10
// - Active report 1100 or 1101 by class
// - One bad frame keeps alignment
// - Mirror received framing bit one
// - Two bad frames lose alignment
// - Fifth good frame regains alignment
// - Lock after 20 good M-bit frames
// - Capture S bits of frames 1,6,11,16
// - Pulse event when captured S bits change
// - Lock status shown beside S bits
// - Send Q bits when locked, else mirror
// - Mirror resumes at next framing bit
// - Disable bit stops multiframe processing
// - Codes persist until replaced
`timescale 1ns/1ns
`include "sil1_map.svh"
module sil1_ctrl
    import sil1_pkg::*;
#(
    parameter int DEACT_CYC = `SIL1_DEACT_MS * `SIL1_CLK_MHZ * 1000,
    parameter int CLK_KHZ   = `SIL1_CLK_MHZ * 1000
) (
    // Clock and reset
    input  wire logic       I_CLK,
    input  wire logic       I_ARST_N,
    // Command and mode
    input  wire logic [3:0] I_CMD_CODE,
    input  wire logic       I_NET_MODE,
    input  wire logic       I_MF_OFF,
    input  wire logic [3:0] I_QBITS,
    input  wire logic       I_LOWER_PRIO,
    // Line events from the receiver, pins
    input  wire logic       I_RX_INFO0,
    input  wire logic       I_RX_WAKE,
    input  wire logic       I_RX_ACTIVE,
    input  wire logic       I_RX_OTHER,
    input  wire logic       I_FRAME_STB,
    input  wire logic       I_FRAME_GOOD,
    input  wire logic       I_RX_FA,
    input  wire logic       I_RX_M,
    input  wire logic       I_RX_S,
    // D channel
    input  wire logic       I_D_TX_REQ,
    input  wire logic       I_D_TX_BIT,
    input  wire logic       I_D_BIT_STB,
    input  wire logic       I_ECHO_BIT,
    // Indication and status
    output logic [3:0]      O_IND_CODE,
    output logic            O_CLK_EN,
    output logic [1:0]      O_TX_INFO,
    output logic            O_PULSE_POS,
    output logic            O_PULSE_NEG,
    output logic [3:0]      O_PRIO,
    output logic            O_D_TX_EN,
    output logic            O_COLLISION,
    output logic            O_FRAME_ALIGNED,
    output logic [4:0]      O_SBIT_RX,
    output logic            O_SBIT_CHG,
    output logic            O_TX_FA
);
    localparam int TW = $clog2(DEACT_CYC + 1);

    // Two flop synchronisers for line, D channel and multiframe disable inputs only
    localparam int NS = 14;
    wire  [NS-1:0] raw = {I_RX_INFO0, I_RX_WAKE, I_RX_ACTIVE, I_RX_OTHER,
                          I_FRAME_STB, I_FRAME_GOOD, I_RX_FA, I_RX_M,
                          I_RX_S, I_D_TX_REQ, I_D_TX_BIT, I_D_BIT_STB,
                          I_ECHO_BIT, I_MF_OFF};
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    wire rx_info0 = s2_q[13];
    wire rx_wake  = s2_q[12];
    wire rx_act   = s2_q[11];
    wire rx_other = s2_q[10];
    wire fstb_lv  = s2_q[9];
    wire fgood    = s2_q[8];
    wire rx_fa    = s2_q[7];
    wire rx_m     = s2_q[6];
    wire rx_s     = s2_q[5];
    wire d_req    = s2_q[4];
    wire d_bit    = s2_q[3];
    wire dstb_lv  = s2_q[2];
    wire echo     = s2_q[1];
    wire mf_off   = s2_q[0];

    logic fstb_d1_q;
    logic dstb_d1_q;
    logic frame_al_q;
    wire  fstb = fstb_lv & ~fstb_d1_q;
    wire  dstb = dstb_lv & ~dstb_d1_q;

    // Activation state machine
    sil1_state_e st_q;
    sil1_state_e st_d;
    logic [TW-1:0] tmr_q;
    wire  cmd_act  = (I_CMD_CODE == `SIL1_CMD_ACT_C1) ||
                     (I_CMD_CODE == `SIL1_CMD_ACT_C2);
    wire  cmd_test = (I_CMD_CODE == `SIL1_CMD_CONT) ||
                     (I_CMD_CODE == `SIL1_CMD_SINGLE);
    wire  tmr_done = (tmr_q == TW'(DEACT_CYC));

    always_comb begin
        st_d = st_q;
        case (st_q)
            SIL1_DEACT: begin
                if (cmd_act || rx_wake)
                    st_d = SIL1_PEND_ACT;
                else if (cmd_test)
                    st_d = SIL1_TEST;
            end
            SIL1_PEND_ACT: begin
                if (I_CMD_CODE == `SIL1_CMD_DEACT)
                    st_d = SIL1_PEND_DEA;
                else if (rx_act && frame_al_q)
                    st_d = SIL1_ACTIVE;
            end
            SIL1_ACTIVE: begin
                if (I_CMD_CODE == `SIL1_CMD_DEACT)
                    st_d = SIL1_PEND_DEA;
                else if (!frame_al_q || rx_other)
                    st_d = SIL1_PEND_ACT;
            end
            SIL1_PEND_DEA: begin
                if (tmr_done || rx_info0)
                    st_d = SIL1_AWAIT_DE;
            end
            SIL1_AWAIT_DE: begin
                if (I_CMD_CODE == `SIL1_CMD_DEACK)
                    st_d = SIL1_DEACT;
            end
            SIL1_TEST: begin
                if (!cmd_test)
                    st_d = SIL1_DEACT;
            end
            default: st_d = SIL1_DEACT;
        endcase
        if (I_CMD_CODE == `SIL1_CMD_RESET)
            st_d = SIL1_PEND_DEA;
        if (!I_NET_MODE)
            st_d = SIL1_DEACT;
    end

    wire [3:0] base_prio = (I_CMD_CODE == `SIL1_CMD_ACT_C2) ?
                           `SIL1_PRIO_C2 : `SIL1_PRIO_C1;
    // Lower level is normal plus one
    wire [3:0] prio_d = cmd_act ?
                        (base_prio | {3'h0, I_LOWER_PRIO}) : O_PRIO;
    wire       class2 = O_PRIO[1];

    wire [3:0] ind_d =
        (I_CMD_CODE == `SIL1_CMD_RESET) ? `SIL1_IND_RESET :
        (st_q == SIL1_ACTIVE) ?
            (class2 ? `SIL1_IND_ACT_C2 : `SIL1_IND_ACT_C1) :
        (st_q == SIL1_PEND_ACT && rx_wake)  ? `SIL1_IND_WAKE :
        (st_q == SIL1_PEND_ACT) ? `SIL1_IND_RESYNC :
        (st_q == SIL1_AWAIT_DE) ? `SIL1_IND_DEACT_DONE :
        (st_q == SIL1_PEND_DEA) ? `SIL1_IND_RESET :
        (st_q == SIL1_DEACT && rx_wake) ? `SIL1_IND_WAKE :
        (st_q == SIL1_TEST) ? `SIL1_IND_TEST : O_IND_CODE;

    wire [1:0] info_d = (st_q == SIL1_ACTIVE)   ? 2'h3 :
                        (st_q == SIL1_PEND_ACT) ? 2'h2 : 2'h0;

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_q       <= SIL1_DEACT;
            tmr_q      <= '0;
            O_IND_CODE <= `SIL1_IND_RESET;
            O_CLK_EN   <= 1'b0;
            O_TX_INFO  <= 2'h0;
            O_PRIO     <= `SIL1_PRIO_C1;
        end else begin
            st_q       <= st_d;
            tmr_q      <= (st_q == SIL1_PEND_DEA && !tmr_done) ?
                          tmr_q + TW'(1) : TW'(0);
            O_IND_CODE <= ind_d;
            O_TX_INFO  <= info_d;
            O_PRIO     <= prio_d;
            O_CLK_EN   <= (st_q != SIL1_DEACT) &&
                          (st_q != SIL1_AWAIT_DE);
        end
    end

    sil1_pulse_gen #(
        .CLK_KHZ (CLK_KHZ)
    ) u_pulse (
        .I_CLK    (I_CLK),
        .I_ARST_N (I_ARST_N),
        .i_cont   (st_q == SIL1_TEST && I_CMD_CODE == `SIL1_CMD_CONT),
        .i_single (st_q == SIL1_TEST && I_CMD_CODE == `SIL1_CMD_SINGLE),
        .o_pos    (O_PULSE_POS),
        .o_neg    (O_PULSE_NEG)
    );

    // D channel collision detection
    // Mismatch stops sending until idle
    wire coll = dstb && O_D_TX_EN && (d_bit != echo);
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_D_TX_EN   <= 1'b0;
            O_COLLISION <= 1'b0;
            dstb_d1_q   <= 1'b0;
        end else begin
            dstb_d1_q   <= dstb_lv;
            O_COLLISION <= coll;
            if (coll || !d_req)
                O_D_TX_EN <= 1'b0;
            else if (dstb && d_req && echo && !O_COLLISION)
                O_D_TX_EN <= 1'b1;
        end
    end

    // Frame alignment counters
    logic [2:0] bad_q;
    logic [2:0] good_q;
    // Alignment flop drives the pin directly
    assign O_FRAME_ALIGNED = frame_al_q;
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            bad_q      <= 3'h0;
            good_q     <= 3'h0;
            frame_al_q <= 1'b0;
            fstb_d1_q  <= 1'b0;
        end else begin
            fstb_d1_q <= fstb_lv;
            if (fstb && frame_al_q) begin
                bad_q <= fgood ? 3'h0 : bad_q + 3'h1;
                if (!fgood && bad_q + 3'h1 >= `SIL1_BAD_LIMIT) begin
                    frame_al_q <= 1'b0;
                    good_q     <= 3'h0;
                end
            end else if (fstb) begin
                good_q <= fgood ? good_q + 3'h1 : 3'h0;
                if (fgood && good_q + 3'h1 >= `SIL1_GOOD_LIMIT) begin
                    frame_al_q <= 1'b1;
                    bad_q      <= 3'h0;
                end
            end
        end
    end

    // Multiframe tracking
    logic [4:0] fnum_q;
    logic [4:0] mcnt_q;
    logic       mlock_q;
    logic [3:0] sbits_q;
    wire  [4:0] fnum_n = (rx_m || fnum_q == `SIL1_MF_LEN) ?
                         5'h1 : fnum_q + 5'h1;
    wire        m_ok   = rx_m == (fnum_n == 5'h1);
    wire        qslot  = (fnum_n == 5'h1) || (fnum_n == 5'h6) ||
                         (fnum_n == 5'hB) || (fnum_n == 5'h10);
    wire [1:0]  qidx   = fnum_n == 5'h1 ? 2'h0 : fnum_n == 5'h6 ? 2'h1 :
                         fnum_n == 5'hB ? 2'h2 : 2'h3;
    wire        mf_run = !mf_off && frame_al_q;
    wire        lose   = fstb && (!m_ok || !fgood);

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            fnum_q  <= 5'h0;
            mcnt_q  <= 5'h0;
            mlock_q <= 1'b0;
            sbits_q <= 4'h0;
            O_SBIT_RX  <= 5'h00;
            O_SBIT_CHG <= 1'b0;
            O_TX_FA    <= 1'b0;
        end else begin
            O_SBIT_CHG <= 1'b0;
            if (!mf_run) begin
                mlock_q <= 1'b0;
                mcnt_q  <= 5'h0;
                fnum_q  <= 5'h0;
            end else if (fstb) begin
                fnum_q <= fnum_n;
                if (lose || (mcnt_q == 5'h0 && fnum_n != 5'h1)) begin
                    mcnt_q  <= 5'h0;
                    mlock_q <= 1'b0;
                end else if (mcnt_q < `SIL1_MF_LOCK) begin
                    mcnt_q <= mcnt_q + 5'h1;
                    if (mcnt_q + 5'h1 == `SIL1_MF_LOCK)
                        mlock_q <= 1'b1;
                end
                if (mlock_q && !lose && qslot)
                    sbits_q[qidx] <= rx_s;
            end
            O_SBIT_RX <= {mlock_q, sbits_q};
            if (mlock_q && O_SBIT_RX[3:0] != sbits_q && O_SBIT_RX[4])
                O_SBIT_CHG <= 1'b1;
            if (fstb)
                O_TX_FA <= (mlock_q && !lose && qslot) ?
                           I_QBITS[qidx] : rx_fa;
        end
    end
endmodule

// >>> inc/sil1_map.svh
// Constants for the S interface layer 1 control block
`ifndef SIL1_MAP_SVH
`define SIL1_MAP_SVH
`define SIL1_CMD_DEACT       4'h0
`define SIL1_CMD_RESET       4'h1
`define SIL1_CMD_SINGLE      4'h2
`define SIL1_CMD_CONT        4'h3
`define SIL1_CMD_ACT_C1      4'h8
`define SIL1_CMD_ACT_C2      4'h9
`define SIL1_CMD_DEACK       4'hF
`define SIL1_IND_TEST        4'h0
`define SIL1_IND_RESET       4'h1
`define SIL1_IND_RESYNC      4'h4
`define SIL1_IND_WAKE        4'h8
`define SIL1_IND_ACT_C1      4'hC
`define SIL1_IND_ACT_C2      4'hD
`define SIL1_IND_DEACT_DONE  4'hF
`define SIL1_PRIO_C1         4'h8
`define SIL1_PRIO_C2         4'hA
`define SIL1_BAD_LIMIT       3'h2
`define SIL1_GOOD_LIMIT      3'h5
`define SIL1_MF_LEN          5'h14
`define SIL1_MF_LOCK         5'h14
`define SIL1_DEACT_MS        25
`define SIL1_CLK_MHZ         50
`define SIL1_CONT_KHZ        96
`define SIL1_SINGLE_KHZ      2
`endif

// >>> inc/sil1_pkg.sv
// Types for the S interface layer 1 control block
package sil1_pkg;
    typedef enum logic [5:0] {
        SIL1_DEACT    = 6'h01,
        SIL1_PEND_ACT = 6'h02,
        SIL1_ACTIVE   = 6'h04,
        SIL1_PEND_DEA = 6'h08,
        SIL1_AWAIT_DE = 6'h10,
        SIL1_TEST     = 6'h20
    } sil1_state_e;
endpackage

// >>> verilog/sil1_pulse_gen.sv
// Test pulse generator: continuous or isolated alternating pulses
`timescale 1ns/1ns
`include "sil1_map.svh"
module sil1_pulse_gen
    import sil1_pkg::*;
#(
    parameter int CLK_KHZ = `SIL1_CLK_MHZ * 1000
) (
    // Clock and reset
    input  wire logic I_CLK,
    input  wire logic I_ARST_N,
    // Control
    input  wire logic i_cont,
    input  wire logic i_single,
    // Pulse outputs
    output logic      o_pos,
    output logic      o_neg
);
    localparam int CONT_DIV = CLK_KHZ / (2 * `SIL1_CONT_KHZ);
    localparam int SNG_DIV  = CLK_KHZ / (2 * `SIL1_SINGLE_KHZ);
    localparam int CW       = $clog2(SNG_DIV + 1);

    logic [CW-1:0] cnt_q;
    logic          pol_q;
    logic          on_q;
    wire  [CW-1:0] lim = i_cont ? CW'(CONT_DIV - 1) : CW'(SNG_DIV - 1);
    wire           wrap = (cnt_q >= lim);
    wire           run  = i_cont | i_single;
    // Isolated pulse lasts one continuous-rate half period
    wire           pulse = i_cont ? on_q : (on_q && cnt_q < CW'(CONT_DIV));

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cnt_q <= '0;
            pol_q <= 1'b0;
            on_q  <= 1'b0;
        end else if (!run) begin
            cnt_q <= '0;
            on_q  <= 1'b0;
        end else if (wrap) begin
            cnt_q <= '0;
            on_q  <= 1'b1;
            pol_q <= ~pol_q;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            o_pos <= 1'b0;
            o_neg <= 1'b0;
        end else begin
            o_pos <= run & pulse & pol_q;
            o_neg <= run & pulse & ~pol_q;
        end
    end
endmodule

// >>> verif/sil1_ctrl_checker.sv
// Port-level assertions for the layer 1 control block
`timescale 1ns/1ns
module sil1_ctrl_checker (
    // Clock and reset
    input wire logic       I_CLK,
    input wire logic       I_ARST_N,
    // Watched ports
    input wire logic       I_MF_OFF,
    input wire logic [3:0] O_IND_CODE,
    input wire logic       O_CLK_EN,
    input wire logic [1:0] O_TX_INFO,
    input wire logic       O_PULSE_POS,
    input wire logic       O_PULSE_NEG,
    input wire logic [3:0] O_PRIO,
    input wire logic       O_D_TX_EN,
    input wire logic       O_COLLISION,
    input wire logic [4:0] O_SBIT_RX,
    input wire logic       O_SBIT_CHG
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    // Pin passes a two-stage synchroniser first
    sequence s_mf_off_held; I_MF_OFF [*5]; endsequence
    sequence s_active_ind; O_IND_CODE[3:1] == 3'h6; endsequence
    property p_prio_range; O_PRIO[3:2] == 2'h2; endproperty
    a_prio_range: assert property (p_prio_range)
        else $error("priority outside 8 to 11");
    property p_class_ind; s_active_ind |-> O_IND_CODE[0] == O_PRIO[1]; endproperty
    a_class_ind: assert property (p_class_ind)
        else $error("active code does not match priority class");
    property p_active_info;
        s_active_ind |-> O_TX_INFO == 2'h3 && O_CLK_EN;
    endproperty
    a_active_info: assert property (p_active_info)
        else $error("active state without INFO4 or clocks");
    property p_coll_stop; O_COLLISION |-> ##[0:1] !O_D_TX_EN; endproperty
    a_coll_stop: assert property (p_coll_stop)
        else $error("D sending kept after collision");
    property p_chg_once; O_SBIT_CHG |=> !O_SBIT_CHG; endproperty
    a_chg_once: assert property (p_chg_once)
        else $error("S change event longer than one cycle");
    property p_chg_cause;
        $changed(O_SBIT_RX[3:0]) |-> ##[0:1] O_SBIT_CHG;
    endproperty
    a_chg_cause: assert property (p_chg_cause)
        else $error("S bits changed without event");
    property p_mf_off; s_mf_off_held |-> !O_SBIT_RX[4]; endproperty
    a_mf_off: assert property (p_mf_off)
        else $error("multiframe lock while disabled");
    property p_pulse_excl; !(O_PULSE_POS && O_PULSE_NEG); endproperty
    a_pulse_excl: assert property (p_pulse_excl)
        else $error("both pulse polarities at once");
endmodule

// >>> verif/sil1_line_model.sv
// Remote terminal model: numbered frames and D echo
`timescale 1ns/1ns
module sil1_line_model (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    // Test controls
    input  wire logic       i_bad,
    input  wire logic       i_collide,
    input  wire logic [3:0] i_spat,
    input  wire logic       i_d_bit,
    // Line events
    output logic            o_stb,
    output logic            o_good,
    output logic            o_fa,
    output logic            o_m,
    output logic            o_s,
    output logic            o_echo
);
    logic [2:0] cyc_q;
    logic [4:0] fr_q;
    wire        slot = fr_q % 5'h5 == 5'h0;
    // Bits only hold around the strobe, inverted in cycles 6 and 7
    wire        inv = cyc_q > 3'h5;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cyc_q <= 3'h0;
            fr_q  <= 5'h0;
        end else begin
            cyc_q <= cyc_q + 3'h1;
            if (cyc_q == 3'h7)
                fr_q <= (fr_q == 5'h13) ? 5'h0 : fr_q + 5'h1;
        end
    end
    assign o_stb  = cyc_q[2:1] == 2'h1;
    assign o_good = !i_bad ^ inv;
    assign o_fa   = slot ^ inv;
    assign o_m    = (fr_q == 5'h0) ^ inv;
    // Same S code in every multiframe
    assign o_s    = (slot & i_spat[fr_q / 5'h5]) ^ inv;
    // Echo disagrees only on command
    assign o_echo = i_d_bit ^ i_collide;
endmodule

// >>> verif/tb.sv
// Self-checking bench for the layer 1 control block
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] rx;
        logic [3:0] ind;
        logic       ind_chk;
        logic [1:0] info;
        logic       info_chk;
    } sil1_row_s;
    // Line events as idle, wake, active, other
    sil1_row_s rows [11] = '{
        '{4'h1, 4'h0, 4'h1, 1'h1, 2'h0, 1'h1},
        '{4'h1, 4'h8, 4'h1, 1'h1, 2'h0, 1'h1},
        '{4'hF, 4'h8, 4'h0, 1'h0, 2'h0, 1'h1},
        '{4'hF, 4'h4, 4'h8, 1'h1, 2'h2, 1'h1},
        '{4'h8, 4'h2, 4'hC, 1'h1, 2'h3, 1'h1},
        '{4'h8, 4'h1, 4'h4, 1'h1, 2'h0, 1'h0},
        '{4'h0, 4'h0, 4'h1, 1'h1, 2'h0, 1'h1},
        '{4'h0, 4'h8, 4'hF, 1'h1, 2'h0, 1'h1},
        '{4'hF, 4'h8, 4'h0, 1'h0, 2'h0, 1'h1},
        '{4'h9, 4'h0, 4'h0, 1'h0, 2'h2, 1'h1},
        '{4'h9, 4'h2, 4'hD, 1'h1, 2'h3, 1'h1}};
    sil1_row_s  r;
    logic       clk = 1'h0, arst_n = 1'h0, mf_off = 1'h0, lower = 1'h0;
    logic [3:0] cmd = 4'hF, qbits = 4'h0, spat = 4'h5, ind, prio;
    logic       idle = 1'h1, wake = 1'h0, act = 1'h0, other = 1'h0;
    logic       d_req = 1'h0, d_bit = 1'h0, d_stb = 1'h0;
    logic       bad = 1'h0, coll = 1'h0;
    logic       f_stb, f_good, f_fa, f_m, f_s, echo, clk_en, p_pos, p_neg;
    logic       dtx_en, c_pulse, chg, tx_fa;
    logic [1:0] tx_info;
    logic [4:0] sbit;
    logic       aligned;
    int         n_errors = 0, comparisons = 0, pos_n = 0, neg_n = 0, cont_n;
    int         coll_n = 0, chg_n = 0, fa_n = 0, base_n;
    sil1_ctrl #(.DEACT_CYC(20), .CLK_KHZ(960)) i_dut (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_CMD_CODE(cmd), .I_NET_MODE(1'h1),
        .I_MF_OFF(mf_off), .I_QBITS(qbits), .I_LOWER_PRIO(lower),
        .I_RX_INFO0(idle), .I_RX_WAKE(wake), .I_RX_ACTIVE(act),
        .I_RX_OTHER(other), .I_FRAME_STB(f_stb), .I_FRAME_GOOD(f_good),
        .I_RX_FA(f_fa), .I_RX_M(f_m), .I_RX_S(f_s), .I_D_TX_REQ(d_req),
        .I_D_TX_BIT(d_bit), .I_D_BIT_STB(d_stb), .I_ECHO_BIT(echo),
        .O_IND_CODE(ind), .O_CLK_EN(clk_en), .O_TX_INFO(tx_info),
        .O_PULSE_POS(p_pos), .O_PULSE_NEG(p_neg), .O_PRIO(prio),
        .O_D_TX_EN(dtx_en), .O_COLLISION(c_pulse), .O_FRAME_ALIGNED(aligned),
        .O_SBIT_RX(sbit), .O_SBIT_CHG(chg), .O_TX_FA(tx_fa));
    sil1_line_model i_line (
        .i_clk(clk), .i_arst_n(arst_n), .i_bad(bad), .i_collide(coll),
        .i_spat(spat), .i_d_bit(d_bit), .o_stb(f_stb), .o_good(f_good),
        .o_fa(f_fa), .o_m(f_m), .o_s(f_s), .o_echo(echo));
    always #10 clk = ~clk;
    always @(posedge p_pos) pos_n++;
    always @(posedge p_neg) neg_n++;
    always @(posedge clk) begin
        if (c_pulse === 1'h1) coll_n++;
        if (chg === 1'h1) chg_n++;
        if (tx_fa === 1'h1) fa_n++;
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_fr(input int n);
        repeat (n) @(posedge f_stb);
        @(negedge clk);
    endtask
    // Bad flag changes between frames, outside the strobe window
    task automatic bad_fr(input int n);
        @(negedge f_stb);
        repeat (3) @(negedge clk);
        bad = 1'h1;
        wait_fr(n);
        repeat (3) @(negedge clk);
        bad = 1'h0;
    endtask
    task automatic send_d(input logic b);
        d_bit = b;
        @(negedge clk) d_stb = 1'h1;
        repeat (2) @(negedge clk);
        d_stb = 1'h0;
        repeat (4) @(negedge clk);
    endtask
    // Whole run is near 6000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        $display("[ERR] watchdog exp done got hang");
        tally_and_finish();
    end
    initial begin
        repeat (12) @(negedge clk);
        chk("rst ind", 8'h01, 8'(ind));  // reset code
        chk("rst clk", 8'h00, 8'(clk_en));  // clocks off
        chk("rst prio", 8'h08, 8'(prio));  // class one
        arst_n = 1'h1;
        repeat (100) @(negedge clk);
        foreach (rows[i]) begin
            r = rows[i];
            // Code held until the next row
            cmd = r.cmd;
            {idle, wake, act, other} = r.rx;
            repeat (8) @(negedge clk);
            if (r.ind_chk)
                chk("ind", 8'(r.ind), 8'(ind));  // code
            if (r.info_chk)
                chk("info", 8'(r.info), 8'(tx_info));  // line
        end
        chk("prio", 8'h0A, 8'(prio));  // class two
        lower = 1'h1;
        repeat (8) @(negedge clk);
        chk("prio", 8'h0B, 8'(prio));  // lower level
        lower = 1'h0;
        d_req = 1'h1;
        repeat (4) send_d(1'h1);
        chk("d en", 8'h01, 8'(dtx_en));  // echo agrees
        coll = 1'h1;
        send_d(1'h0);
        chk("coll", 8'h01, 8'(coll_n != 0));  // clash seen
        chk("d en", 8'h00, 8'(dtx_en));  // sending stopped
        {coll, d_req} = 2'h0;
        // Over three multiframes of one code
        wait_fr(65);
        chk("sbit", 8'h15, 8'(sbit));  // lock
        base_n = fa_n;
        wait_fr(20);
        chk("q fa", 8'h00, 8'(fa_n != base_n));  // Q bits sent
        base_n = chg_n;
        spat = 4'hA;
        wait_fr(65);
        chk("chg", 8'h01, 8'(chg_n != base_n));  // event
        chk("sbit", 8'h1A, 8'(sbit));  // new S bits
        bad_fr(1);
        wait_fr(2);
        chk("aligned", 8'h01, 8'(aligned));  // one bad frame
        bad_fr(2);
        wait_fr(2);
        chk("aligned", 8'h00, 8'(aligned));  // two bad frames
        wait_fr(8);
        chk("ind", 8'h0D, 8'(ind));  // realigned
        chk("aligned", 8'h01, 8'(aligned));  // regained
        wait_fr(45);
        chk("lock", 8'h01, 8'(sbit[4]));  // relocked
        mf_off = 1'h1;
        base_n = fa_n;
        wait_fr(20);
        chk("lock", 8'h00, 8'(sbit[4]));  // disabled
        chk("mirror", 8'h01, 8'(fa_n != base_n));
        mf_off = 1'h0;
        // Deactivate first: test modes start only from deactivated
        cmd = 4'h0;
        {idle, wake, act, other} = 4'h0;
        repeat (40) @(negedge clk);
        chk("timer", 8'h0F, 8'(ind));  // timer expiry
        cmd = 4'hF;
        repeat (8) @(negedge clk);
        chk("clk en", 8'h00, 8'(clk_en));  // deactivated
        chk("no pulse", 8'h00, 8'(pos_n + neg_n != 0));  // normal
        cmd = 4'h3;
        repeat (2000) @(negedge clk);
        cont_n = pos_n;
        chk("cont", 8'h01, 8'(pos_n > 0 && neg_n > 0));  // both
        cmd = 4'h2;
        repeat (2000) @(negedge clk);
        base_n = pos_n - cont_n;
        chk("single", 8'h01, 8'(base_n > 0 && base_n < cont_n));
        tally_and_finish();
    end
endmodule
bind sil1_ctrl sil1_ctrl_checker i_chk (
    .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_MF_OFF(I_MF_OFF),
    .O_IND_CODE(O_IND_CODE), .O_CLK_EN(O_CLK_EN), .O_TX_INFO(O_TX_INFO),
    .O_PULSE_POS(O_PULSE_POS), .O_PULSE_NEG(O_PULSE_NEG), .O_PRIO(O_PRIO),
    .O_D_TX_EN(O_D_TX_EN), .O_COLLISION(O_COLLISION),
    .O_SBIT_RX(O_SBIT_RX), .O_SBIT_CHG(O_SBIT_CHG));
